// *** inc/efs_pkg.sv ***
// Constants shared by the electrode select and reset supervisor logic
`default_nettype none
package efs_pkg;

  // Pins reached by the transmit and receive multiplexers: nine electrodes, two references
  localparam int NUM_PINS = 11;
  localparam int NUM_NODES = 2;

  // Select code values
  localparam logic [3:0] CODE_SOURCE = 4'h0;
  localparam logic [3:0] CODE_FIRST_PIN = 4'h1;
  localparam logic [3:0] CODE_OSC_RAW = 4'hC;
  localparam logic [3:0] CODE_OSC_SERIES = 4'hD;
  localparam logic [3:0] CODE_GROUND = 4'hE;
  localparam logic [3:0] CODE_RESERVED = 4'hF;

  // Oscillator and supervisor times
  localparam int OSC_FREQ_KHZ = 120;
  localparam int POR_TIME_US = 9000;
  localparam int WD_HOLD_TIME_US = 9000;
  localparam int WD_TIME_US = 68000;

  // Least times round up, the typical watchdog time rounds down
  localparam int POR_CYCLES = (POR_TIME_US * OSC_FREQ_KHZ + 999) / 1000;
  localparam int WD_HOLD_CYCLES = (WD_HOLD_TIME_US * OSC_FREQ_KHZ + 999) / 1000;
  localparam int WD_CYCLES = (WD_TIME_US * OSC_FREQ_KHZ) / 1000;

  // Counter width in oscillator cycles
  localparam int CNT_W = 14;

  // Values after reset
  localparam logic [NUM_PINS-1:0] PIN_SEL_RESET = 11'h000;
  localparam logic [NUM_PINS-1:0] GROUND_RESET = 11'h7FF;
  localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;

  // Supervisor states
  typedef enum logic [2:0] {
    SV_POR = 3'b001,
    SV_RUN = 3'b010,
    SV_WDHOLD = 3'b100
  } efs_sv_state_t;

endpackage : efs_pkg
`default_nettype wire

// *** inc/efs_sel_if.sv ***
// Select code and its decoded selections between the top and the decoder
`timescale 1ns/10ps
`default_nettype none
interface efs_sel_if;
  import efs_pkg::*;
  logic [3:0] code;
  logic [NUM_PINS-1:0] pinSel;
  logic [NUM_NODES-1:0] nodeSel;
  logic srcSel;
  logic gndSel;
  modport decoder (input code, output pinSel, output nodeSel, output srcSel, output gndSel);
  modport user (output code, input pinSel, input nodeSel, input srcSel, input gndSel);
endinterface : efs_sel_if
`default_nettype wire

// *** logic/efs_select_decoder.sv ***
// Combinational decoder of the electrode select code
`timescale 1ns/10ps
`default_nettype none
module efs_select_decoder (
  efs_sel_if.decoder sel
);
  import efs_pkg::*;

  // Compare the code with one value
  function automatic logic codeIs(input logic [3:0] code, input logic [3:0] value);
    codeIs = (code == value);
  endfunction : codeIs

  // One pin line per electrode and reference; reserved and internal codes drive none
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      assign sel.pinSel[i] = codeIs(sel.code, CODE_FIRST_PIN + 4'(i));
    end
  endgenerate

  // Internal nodes for the detector and the internal source and ground
  assign sel.nodeSel[0] = codeIs(sel.code, CODE_OSC_RAW);
  assign sel.nodeSel[1] = codeIs(sel.code, CODE_OSC_SERIES);
  assign sel.srcSel = codeIs(sel.code, CODE_SOURCE);
  assign sel.gndSel = codeIs(sel.code, CODE_GROUND);

endmodule : efs_select_decoder
`default_nettype wire

// *** logic/efs_mux_supervisor.sv ***
// Electrode multiplexer control and power-on/watchdog reset supervisor
//
// Contract
// - Host drives a 4-bit code; excitation goes to at most one of eleven pins, none for codes 0 and 12-15.
// - Code 0 source, 1-9 electrodes, 10-11 references, 12-13 internal nodes, 14 internal ground, 15 reserved.
// - Every unselected electrode or reference output is grounded automatically.
// - Receive multiplexer connects the same pin that transmit drives.
// - Receive multiplexer may instead pick one of two internal nodes by code.
// - Clock output is a square wave at the oscillator frequency.
// - Reset and watchdog times are counted in oscillator cycles, nominally 120 kHz.
// - Missing kick for the watchdog time forces reset, held 9 to 50 ms.
// - Reset held until supply stays valid for the time-out; restarts on any dip.
// - Supply above its maximum also forces reset.
`timescale 1ns/10ps
`default_nettype none
module efs_mux_supervisor #(
  parameter int WD_CYCLES_P = efs_pkg::WD_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] electrodeSelectCode,
  input wire logic watchdogKickInput,
  input wire logic oscSquareIn,
  input wire logic supplyLow,
  input wire logic supplyHigh,
  output logic [efs_pkg::NUM_PINS-1:0] txPinSel,
  output logic [efs_pkg::NUM_PINS-1:0] groundPin,
  output logic [efs_pkg::NUM_PINS-1:0] rxPinSel,
  output logic [efs_pkg::NUM_NODES-1:0] rxNodeSel,
  output logic sourceSel,
  output logic groundSel,
  output logic clkOut,
  output logic rstOut_n
);
  import efs_pkg::*;

  // Pin synchronisers, first stage read only by the second
  logic [3:0] codeS1;
  logic [3:0] codeS2;
  logic kickS1;
  logic kickS2;
  logic kickS3;
  logic oscS1;
  logic oscS2;
  logic oscS3;
  logic lowS1;
  logic lowS2;
  logic highS1;
  logic highS2;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      codeS1 <= CODE_RESERVED;
      codeS2 <= CODE_RESERVED;
      kickS1 <= 1'b0;
      kickS2 <= 1'b0;
      kickS3 <= 1'b0;
      oscS1 <= 1'b0;
      oscS2 <= 1'b0;
      oscS3 <= 1'b0;
      lowS1 <= 1'b1;
      lowS2 <= 1'b1;
      highS1 <= 1'b0;
      highS2 <= 1'b0;
    end else begin
      codeS1 <= electrodeSelectCode;
      codeS2 <= codeS1;
      kickS1 <= watchdogKickInput;
      kickS2 <= kickS1;
      kickS3 <= kickS2;
      oscS1 <= oscSquareIn;
      oscS2 <= oscS1;
      oscS3 <= oscS2;
      lowS1 <= supplyLow;
      lowS2 <= lowS1;
      highS1 <= supplyHigh;
      highS2 <= highS1;
    end
  end

  // Edge detection and supply condition
  logic oscTick;
  logic kickRise;
  logic supplyOk;
  assign oscTick = oscS2 & ~oscS3;
  assign kickRise = kickS2 & ~kickS3;
  assign supplyOk = ~lowS2 & ~highS2;

  // Select decoding
  efs_sel_if selIf ();
  assign selIf.code = codeS2;
  efs_select_decoder u_decoder (
    .sel(selIf)
  );

  // Registered multiplexer controls
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txPinSel <= PIN_SEL_RESET;
      rxPinSel <= PIN_SEL_RESET;
      groundPin <= GROUND_RESET;
      rxNodeSel <= '0;
      sourceSel <= 1'b0;
      groundSel <= 1'b0;
    end else begin
      txPinSel <= selIf.pinSel;
      rxPinSel <= selIf.pinSel;
      groundPin <= ~selIf.pinSel;
      rxNodeSel <= selIf.nodeSel;
      sourceSel <= selIf.srcSel;
      groundSel <= selIf.gndSel;
    end
  end

  // Square clock output follows the synchronised oscillator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkOut <= 1'b0;
    end else begin
      clkOut <= oscS3;
    end
  end

  // Supervisor next state; supply fault always restarts the power-on interval
  efs_sv_state_t state;
  efs_sv_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic porDone;
  logic wdExpired;
  logic holdDone;
  assign porDone = oscTick && (cnt == CNT_W'(POR_CYCLES - 1));
  assign wdExpired = oscTick && !kickRise && (cnt == CNT_W'(WD_CYCLES_P - 1));
  assign holdDone = oscTick && (cnt == CNT_W'(WD_HOLD_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!supplyOk) begin
      next_state = SV_POR;
      next_cnt = CNT_RESET;
    end else begin
      unique case (state)
        SV_POR: begin
          if (porDone) begin
            next_state = SV_RUN;
            next_cnt = CNT_RESET;
          end else if (oscTick) begin
            next_cnt = cnt + 1'b1;
          end
        end
        SV_RUN: begin
          if (kickRise) begin
            next_cnt = CNT_RESET;
          end else if (wdExpired) begin
            next_state = SV_WDHOLD;
            next_cnt = CNT_RESET;
          end else if (oscTick) begin
            next_cnt = cnt + 1'b1;
          end
        end
        SV_WDHOLD: begin
          if (holdDone) begin
            next_state = SV_RUN;
            next_cnt = CNT_RESET;
          end else if (oscTick) begin
            next_cnt = cnt + 1'b1;
          end
        end
        default: begin
          next_state = SV_POR;
          next_cnt = CNT_RESET;
        end
      endcase
    end
  end

  // Supervisor registers; reset output released only in the running state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SV_POR;
      cnt <= CNT_RESET;
      rstOut_n <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rstOut_n <= (next_state == SV_RUN);
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_tx_one_pin: assert property ($onehot0(txPinSel))
    else $error("more than one pin driven");
  a_gnd_unselected: assert property (groundPin == ~txPinSel)
    else $error("unselected pin not grounded or selected pin grounded");
  a_rx_tracks_tx: assert property (rxPinSel == txPinSel)
    else $error("receive pin differs from transmit pin");
  a_code_pin_map: assert property (codeS2 == 4'hA |=> txPinSel == 11'h200 && !sourceSel)
    else $error("first reference not selected by its code");
  a_node_select: assert property (codeS2 == CODE_OSC_SERIES |=> rxNodeSel == 2'b10 && txPinSel == '0)
    else $error("internal node not routed to detector");
  a_reserved_ground: assert property (codeS2 == CODE_RESERVED |=> groundPin == 11'h7FF && rxNodeSel == '0)
    else $error("reserved code left a pin ungrounded");
  a_clk_follows: assert property ($rose(oscS2) |=> ##1 clkOut)
    else $error("clock output missed oscillator edge");
  a_supply_reset: assert property (!supplyOk |=> !rstOut_n && state == SV_POR)
    else $error("supply fault did not force reset");
  a_wd_expiry: assert property (state == SV_RUN && wdExpired && supplyOk |=> !rstOut_n [*2])
    else $error("watchdog expiry did not force reset");
  a_release_tick: assert property ($rose(rstOut_n) |-> $past(oscTick))
    else $error("reset released without an oscillator cycle");

  c_por_release: cover property (state == SV_POR ##1 state == SV_RUN);
  c_wd_reset: cover property (state == SV_RUN ##1 state == SV_WDHOLD);
  c_kick_seen: cover property (state == SV_RUN && kickRise);
  c_node_chosen: cover property (rxNodeSel == 2'b01);

endmodule : efs_mux_supervisor
`default_nettype wire

// *** tb/efs_host_model.sv ***
// Host-side model that kicks the watchdog while enabled
`timescale 1ns/10ps
`default_nettype none
module efs_host_model #(
  parameter int HALF_PERIOD = 30
) (
  input wire logic clk,
  input wire logic kickEnable,
  output logic kick
);
  // Rising kick edges every 2 * HALF_PERIOD clocks, well inside the watchdog time-out
  initial begin
    kick = 1'b0;
    forever begin
      repeat (HALF_PERIOD) @(posedge clk);
      #1 kick = kickEnable ? ~kick : 1'b0;
    end
  end
endmodule : efs_host_model
`default_nettype wire

// *** tb/efs_mux_supervisor_test.sv ***
// Self-checking bench for the electrode multiplexer and reset supervisor
`timescale 1ns/10ps
`default_nettype none
module efs_mux_supervisor_test;
  import efs_pkg::*;
  typedef struct {logic [3:0] code; logic [NUM_PINS-1:0] tx; logic [NUM_NODES-1:0] node;
    logic src; logic gnd;} efs_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] code = CODE_RESERVED;
  logic osc = 1'b0;
  logic supplyLow = 1'b1;
  logic supplyHigh = 1'b0;
  logic kickEnable = 1'b0;
  wire logic kick;
  logic [NUM_PINS-1:0] txPinSel, groundPin, rxPinSel;
  logic [NUM_NODES-1:0] rxNodeSel;
  logic sourceSel, groundSel, clkOut, rstOut_n;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  efs_row_t rows[16];

  // Clock at 250 MHz and oscillator with a 12-clock period
  always #2 clk = ~clk;
  always begin
    repeat (6) @(posedge clk);
    #1 osc = ~osc;
  end

  efs_mux_supervisor #(.WD_CYCLES_P(20)) DUT (.clk(clk), .sys_rst(sys_rst),
    .electrodeSelectCode(code), .watchdogKickInput(kick), .oscSquareIn(osc),
    .supplyLow(supplyLow), .supplyHigh(supplyHigh), .txPinSel(txPinSel),
    .groundPin(groundPin), .rxPinSel(rxPinSel), .rxNodeSel(rxNodeSel),
    .sourceSel(sourceSel), .groundSel(groundSel), .clkOut(clkOut), .rstOut_n(rstOut_n));

  efs_host_model host (.clk(clk), .kickEnable(kickEnable), .kick(kick));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : edges

  task automatic ticks(input int n);
    repeat (n) @(posedge osc);
  endtask : ticks

  // Waits a bounded number of oscillator cycles for the reset output level
  task automatic wait_rst(input logic want, input int maxTicks);
    int n;
    n = 0;
    while (rstOut_n !== want && n < maxTicks) begin
      @(posedge osc);
      n++;
    end
    check(16'(rstOut_n), 16'(want));
  endtask : wait_rst

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    edges(4);
    check(16'(groundPin), 16'(GROUND_RESET));
    check(16'(txPinSel), 16'h0000);
    check(16'(rstOut_n), 16'h0000);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) rows[i] = '{4'(i), '0, '0, 1'b0, 1'b0};
    for (int i = 1; i <= NUM_PINS; i++) rows[i].tx = 11'(1) << (i - 1);
    rows[0].src = 1'b1;
    rows[12].node = 2'h1;
    rows[13].node = 2'h2;
    rows[14].gnd = 1'b1;
    foreach (rows[i]) begin
      code = rows[i].code;
      edges(4);
      check(16'(txPinSel), 16'(rows[i].tx));
      check(16'(groundPin), 16'(GROUND_RESET ^ rows[i].tx));
      check(16'(rxPinSel), 16'(rows[i].tx));
      check(16'(rxNodeSel), 16'(rows[i].node));
      check(16'({sourceSel, groundSel}), 16'({rows[i].src, rows[i].gnd}));
    end
    // Back-to-back codes ending on the reserved one
    code = 4'h3;
    edges(1);
    code = CODE_RESERVED;
    edges(2);
    check(16'(txPinSel), 16'h0004);
    edges(2);
    check(16'(groundPin), 16'(GROUND_RESET));
    @(posedge osc);
    edges(5);
    check(16'(clkOut), 16'h0001);
    edges(6);
    check(16'(clkOut), 16'h0000);
    // Power-on time-out, then watchdog expiry and hold
    supplyLow = 1'b0;
    ticks(POR_CYCLES);
    check(16'(rstOut_n), 16'h0000);
    wait_rst(1'b1, 4);
    kickEnable = 1'b1;
    ticks(100);
    check(16'(rstOut_n), 16'h0001);
    kickEnable = 1'b0;
    wait_rst(1'b0, 30);
    ticks(WD_HOLD_CYCLES - 1);
    check(16'(rstOut_n), 16'h0000);
    kickEnable = 1'b1;
    wait_rst(1'b1, 4);
    // Over-voltage, then a supply dip that restarts the power-on count
    supplyHigh = 1'b1;
    edges(5);
    check(16'(rstOut_n), 16'h0000);
    supplyHigh = 1'b0;
    ticks(600);
    supplyLow = 1'b1;
    edges(3);
    supplyLow = 1'b0;
    ticks(POR_CYCLES);
    check(16'(rstOut_n), 16'h0000);
    wait_rst(1'b1, 4);
    // Reset in mid-run returns the transmit, ground, clock and reset outputs to their reset values
    code = 4'h5;
    edges(4);
    check(16'(txPinSel), 16'h0010);
    sys_rst = 1'b1;
    edges(1);
    check(16'(txPinSel), 16'h0000);
    check(16'(groundPin), 16'(GROUND_RESET));
    check(16'(clkOut), 16'h0000);
    check(16'(rstOut_n), 16'h0000);
    sys_rst = 1'b0;
    edges(4);
    check(16'(rxPinSel), 16'h0010);
    check(16'(groundPin), 16'h07EF);
    check(16'(rstOut_n), 16'h0000);
    complete_run();
  end
endmodule : efs_mux_supervisor_test
`default_nettype wire
